// ===== core/cosip_map.vh
// Purpose: Addresses, field positions and reset values of the object status block
// Assumes: 8-bit special function register bus, byte addresses as printed
// Notes:   Definitions only
`ifndef COSIP_MAP_VH
`define COSIP_MAP_VH
`define COSIP_ADDR_BAUD_PRESCALE     8'hB4
`define COSIP_ADDR_PENDING_HIGH      8'hBA
`define COSIP_ADDR_PENDING_LOW       8'hBB
`define COSIP_ADDR_ENABLE_HIGH       8'hC2
`define COSIP_ADDR_ENABLE_LOW        8'hC3
`define COSIP_ADDR_ACTIVE_HIGH       8'hCE
`define COSIP_ADDR_ACTIVE_LOW        8'hCF
`define COSIP_OBJ_COUNT              15
`define COSIP_LOW_OBJS               8
`define COSIP_PRESCALER_LSB          1
`define COSIP_PRESCALER_MSB          6
`define COSIP_PRESCALER_W            6
`define COSIP_PRESCALE_RESET         8'h00
`define COSIP_REG_RESET              8'h00
`define COSIP_CFG_DISABLE            2'h0
`endif

// ===== core/cosip_core.v
// Purpose: Message object active, pending and enable bookkeeping plus quantum prescaler
// Assumes: Single clock, synchronous register port, object engine reports events as pulses
// Notes:   Reserved bits read as zero; prescaler reset chosen as zero
//
// Behaviour
// [R1] Active bits: objects 14..8 in high register 6-0, objects 7..0 in low 7-0.
// [R2] Active bit 0 means object free; 1 means object enabled.
// [R3] Object completion clears its active bit; a configuration rewrite sets it by mode; no direct writes.
// [R4] Pending bit reads 1 until software clears the underlying interrupt condition.
// [R5] High pending register bit n is object n+8.
// [R6] Low pending register bit n is object n.
// [R7] One writable interrupt enable per object, split over two registers.
// [R8] High enable register bit n enables object n+8.
// [R9] Low enable register bit n enables object n.
// [R10] Quantum period is prescaler value plus one clocks, prescaler in bits 6-1.
// [R11] Software never writes ones to reserved bits; they read undefined. This core reads them as zero.
// [R12] Software touches the prescaler only while the controller is switched off.
// [R13] Summary flag mirrors every forwarded controller interrupt, usable for polling.
// [R14] Software rewrites the configuration field to make an object active again.
// [R15] Pending status reaches the summary only when its enable is set.
// [R16] Writes to active and pending registers are ignored.
`include "cosip_map.vh"
module cosip_core #(
	parameter OBJS = `COSIP_OBJ_COUNT
) (
	input  wire            i_sys_clk,
	input  wire            i_resetn,
	input  wire [7:0]      i_sfr_addr,
	input  wire [7:0]      i_sfr_wdata,
	input  wire            i_sfr_wr,
	input  wire            i_sfr_rd,
	input  wire            i_cfg_wr,
	input  wire [3:0]      i_cfg_obj,
	input  wire [1:0]      i_cfg_mode,
	input  wire [OBJS-1:0] i_obj_done,
	input  wire [OBJS-1:0] i_irq_set,
	input  wire [OBJS-1:0] i_irq_clr,
	input  wire            i_controller_on,
	input  wire            i_other_irq,
	output reg  [7:0]      o_sfr_rdata,
	output reg             o_summary_irq_flag,
	output reg             o_quantum_tick,
	output reg  [5:0]      o_quantum_prescaler
);

	reg  [OBJS-1:0] obj_active_r;
	reg  [OBJS-1:0] obj_irq_pending_r;
	reg  [OBJS-1:0] obj_irq_enable_r;
	reg  [5:0]      quantum_cnt_r;
	reg  [7:0]      rdata_nxt;
	wire [15:0]     act_w;
	wire [15:0]     pend_w;
	wire [15:0]     ien_w;

	// Zero-pad to sixteen; reserved bit 7 of high registers reads 0 from the read mux
	assign act_w  = {{(16-OBJS){1'b0}}, obj_active_r};
	assign pend_w = {{(16-OBJS){1'b0}}, obj_irq_pending_r};
	assign ien_w  = {{(16-OBJS){1'b0}}, obj_irq_enable_r};

	// Per-object state; configuration rewrite wins over a done event
	genvar g;
	generate
		for (g = 0; g < OBJS; g = g + 1) begin : g_obj
			// Object index at the select width, so the compare needs no padding
			localparam [3:0] OBJ_IDX = g;
			wire cfg_hit = i_cfg_wr && (i_cfg_obj == OBJ_IDX);
			always @(posedge i_sys_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					obj_active_r[g]      <= 1'b0;
					obj_irq_pending_r[g] <= 1'b0;
				end else begin
					if (cfg_hit) // [R3]
						obj_active_r[g] <= (i_cfg_mode != `COSIP_CFG_DISABLE); // [R2]
					else if (i_obj_done[g])
						obj_active_r[g] <= 1'b0; // [R2]
					// Set beats clear so a fresh event is never lost
					if (i_irq_set[g])
						obj_irq_pending_r[g] <= 1'b1; // [R4]
					else if (i_irq_clr[g])
						obj_irq_pending_r[g] <= 1'b0; // [R4]
				end
			end
		end
	endgenerate

	// Writable registers; active and pending addresses take no write
	always @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			obj_irq_enable_r    <= {OBJS{1'b0}};
			o_quantum_prescaler <= 6'h0;
		end else if (i_sfr_wr) begin
			case (i_sfr_addr)
			`COSIP_ADDR_ENABLE_HIGH: begin
				obj_irq_enable_r[OBJS-1:8] <= i_sfr_wdata[OBJS-9:0]; // [R8]
			end
			`COSIP_ADDR_ENABLE_LOW: begin
				obj_irq_enable_r[7:0] <= i_sfr_wdata; // [R7] [R9]
			end
			`COSIP_ADDR_BAUD_PRESCALE: begin
				// Not guarded by controller_on: software keeps that discipline
				o_quantum_prescaler <= i_sfr_wdata[6:1]; // [R10]
			end
			default: begin
				obj_irq_enable_r <= obj_irq_enable_r; // [R16]
			end
			endcase
		end
	end

	// Read mux, unmapped addresses read zero
	always @* begin
		case (i_sfr_addr)
		`COSIP_ADDR_ACTIVE_HIGH:   rdata_nxt = {1'b0, act_w[14:8]}; // [R1]
		`COSIP_ADDR_ACTIVE_LOW:    rdata_nxt = act_w[7:0]; // [R1]
		`COSIP_ADDR_PENDING_HIGH:  rdata_nxt = {1'b0, pend_w[14:8]}; // [R5]
		`COSIP_ADDR_PENDING_LOW:   rdata_nxt = pend_w[7:0]; // [R6]
		`COSIP_ADDR_ENABLE_HIGH:   rdata_nxt = {1'b0, ien_w[14:8]}; // [R8]
		`COSIP_ADDR_ENABLE_LOW:    rdata_nxt = ien_w[7:0]; // [R9]
		`COSIP_ADDR_BAUD_PRESCALE: rdata_nxt = {1'b0, o_quantum_prescaler, 1'b0};
		default:                   rdata_nxt = 8'h00;
		endcase
	end

	// Registered read data, summary flag and quantum divider
	always @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sfr_rdata        <= `COSIP_REG_RESET;
			o_summary_irq_flag <= 1'b0;
			quantum_cnt_r      <= 6'h0;
			o_quantum_tick     <= 1'b0;
		end else begin
			if (i_sfr_rd)
				o_sfr_rdata <= rdata_nxt;
			o_summary_irq_flag <= (|(obj_irq_pending_r & obj_irq_enable_r)) | i_other_irq; // [R13] [R15]
			// Divider held in reset while controller is off, so rewrites start clean
			if (!i_controller_on || quantum_cnt_r == o_quantum_prescaler) begin
				quantum_cnt_r  <= 6'h0;
				o_quantum_tick <= i_controller_on; // [R10]
			end else begin
				quantum_cnt_r  <= quantum_cnt_r + 6'h1;
				o_quantum_tick <= 1'b0;
			end
		end
	end

endmodule

// ===== tb/cosip_chk_asserts.sv
// Purpose: port checks of cosip_core. Assumes: one clock. Notes: bound below
module cosip_chk #(parameter OBJS = 15) (input wire logic i_sys_clk, i_resetn, i_sfr_wr,
	input wire logic i_sfr_rd, i_other_irq, i_controller_on, o_summary_irq_flag, o_quantum_tick,
	input wire logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata,
	input wire logic [5:0] o_quantum_prescaler);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	chk_rsv_bit: assert property (i_sfr_rd && i_sfr_addr == 8'hCE |=> !o_sfr_rdata[7])
		else $error("bit 7 set");
	chk_bad_rd: assert property (i_sfr_rd && i_sfr_addr == 8'h00 |=> o_sfr_rdata == 8'h00)
		else $error("unmapped");
	chk_rd_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata)) else $error("hold");
	chk_other_irq: assert property (i_other_irq |=> o_summary_irq_flag) else $error("flag");
	chk_presc_wr: assert property (i_sfr_wr && i_sfr_addr == 8'hB4 |=>
		o_quantum_prescaler == $past(i_sfr_wdata[6:1])) else $error("prescaler");
	chk_tick_off: assert property (!i_controller_on |=> !o_quantum_tick) else $error("off");
	chk_tick_gap: assert property (o_quantum_tick && o_quantum_prescaler != 6'h00 |=>
		!o_quantum_tick) else $error("gap");
	chk_tick_per: assert property (o_quantum_tick && o_quantum_prescaler == 6'h02 ##1
		i_controller_on [*3] |-> o_quantum_tick) else $error("period");
	cover property (o_summary_irq_flag);
	cover property (o_quantum_tick);
	cover property (i_sfr_wr && i_sfr_addr == 8'hB4);
endmodule
bind cosip_core cosip_chk #(.OBJS(OBJS)) u_chk (.*);

// ===== tb/cosip_cpu.sv
// Purpose: CPU register access model. Assumes: one clock. Notes: data inverted once released
module cosip_cpu (input wire logic i_clk, input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr = 8'h00, o_wdata = 8'h00, output logic o_wr = 0, o_rd = 0, o_on = 0);
	timeunit 1ns;
	timeprecision 1ns;
	// One access; r high reads, held until the taking edge
	task automatic x(input logic r, input logic [7:0] ad, dt, output logic [7:0] d);
		@(posedge i_clk);
		if (!r && ad == 8'hB4) o_on <= 1'b0;
		{o_addr, o_wr, o_rd} <= {ad, !r, r};
		o_wdata <= dt & (ad == 8'hB4 ? 8'h7E : ad[0] ? 8'hFF : 8'h7F);
		@(posedge i_clk);
		{o_wdata, o_wr, o_rd} <= {~o_wdata, 2'b00};
		#1 d = i_rdata;
	endtask
endmodule

// ===== tb/test_can_object_status_irq_prescaler.sv
// Purpose: bench for cosip_core. Assumes: 25 MHz clock. Notes: int scoreboard
module test_can_object_status_irq_prescaler;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk = 0, i_resetn = 0, i_cfg_wr = 0, i_other_irq = 0, i_sfr_wr, i_sfr_rd;
	logic i_controller_on, o_summary_irq_flag, o_quantum_tick;
	logic [14:0] i_irq_set = 0, i_irq_clr = 0, i_obj_done = 0;
	logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, d;
	logic [7:0] ad [7] = '{8'hB4, 8'hBA, 8'hBB, 8'hC2, 8'hC3, 8'hCE, 8'h00};
	logic [3:0] i_cfg_obj = 0;
	logic [1:0] i_cfg_mode = 0;
	logic [5:0] o_quantum_prescaler;
	int failures = 0, check_count = 0, seed = 81, act = 0, pend = 0, en = 0, n;
	always #20 i_sys_clk = ~i_sys_clk;
	cosip_core dut (.*);
	cosip_cpu cpu (.i_clk(i_sys_clk), .i_rdata(o_sfr_rdata), .o_addr(i_sfr_addr),
		.o_wdata(i_sfr_wdata), .o_wr(i_sfr_wr), .o_rd(i_sfr_rd), .o_on(i_controller_on));
	task automatic chk(input logic [7:0] s, e);
		check_count++;
		if (s !== e) failures++;
		if (s !== e) $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic rc(input logic [7:0] a, input int e);
		cpu.x(1, a, 8'h00, d);
		chk(d, e[7:0]);
	endtask
	// Pulse events and score them; set beats clear, done frees the object
	task automatic ev(input logic [14:0] s, k, f, input int o, m);
		@(posedge i_sys_clk);
		{i_irq_set, i_irq_clr, i_obj_done, i_cfg_wr, i_cfg_obj, i_cfg_mode} <=
			{s, k, f, (o >= 0), o[3:0], m[1:0]};
		@(posedge i_sys_clk);
		{i_irq_set, i_irq_clr, i_obj_done, i_cfg_wr} <= '0;
		pend = pend & ~k | s;
		act = o < 0 ? act & ~f : m ? act | 1 << o : act & ~(1 << o);
		#41 chk(o_summary_irq_flag, (pend & en) != 0 || i_other_irq);
	endtask
	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_resetn <= 1;
		foreach (ad[i]) rc(ad[i], 0);
		cpu.x(0, 8'hCE, 8'hFF, d);
		cpu.x(0, 8'hBB, 8'hFF, d);
		rc(8'hCE, 0);
		rc(8'hBB, 0);
		for (int i = 0; i < 6; i++) begin
			n = i < 4 ? $random(seed) : 12;
			cpu.x(0, 8'hC2 + i[0], n[7:0], d);
			rc(8'hC2 + i[0], n & (i[0] ? 255 : 127));
		end
		en = 32'h0C0C;
		ev(0, 0, 0, 3, 1);
		ev(0, 0, 0, 11, 2);
		ev(0, 0, 0, 0, 3);
		rc(8'hCE, act >> 8);
		ev(0, 0, 0, 3, 0);
		ev(0, 0, 15'h0800, -1, 0);
		rc(8'hCF, act);
		rc(8'hCE, act >> 8);
		ev(15'h0909, 0, 0, -1, 0);
		rc(8'hBB, pend);
		rc(8'hBA, pend >> 8);
		ev(0, 15'h0808, 0, -1, 0);
		ev(4, 4, 0, -1, 0);
		rc(8'hBB, pend);
		@(posedge i_sys_clk) i_other_irq <= 1;
		#41 chk(o_summary_irq_flag, 1);
		cpu.x(0, 8'hB4, 8'h85, d);
		#1 chk(o_quantum_prescaler, 2);
		rc(8'hB4, 8'h04);
		@(posedge i_sys_clk) cpu.o_on <= 1;
		for (n = 0; n < 9 && o_quantum_tick !== 1; n++) @(posedge i_sys_clk) #1;
		for (n = 1; n < 9; n++) @(posedge i_sys_clk) #1 if (o_quantum_tick) break;
		chk(n[7:0], 3);
		repeat (4) @(posedge i_sys_clk);
		tally_and_finish;
	end
	initial begin
		#100000 failures++;
		tally_and_finish;
	end
endmodule
